/* File: design/flash_seq_cfg.svh */
// constants of the program-once flash command sequencer
`ifndef FLASH_SEQ_CFG_SVH
`define FLASH_SEQ_CFG_SVH

// register indices, byte address is four times the index
`define REG_IDX_CLKDIV 6'h00
`define REG_IDX_STATUS 6'h01
`define REG_IDX_PINDEX 6'h02
`define REG_IDX_PWORD 6'h03
`define REG_IDX_PROT 6'h04
`define REG_IDX_IRQ_STAT 6'h05
`define REG_IDX_IRQ_MASK 6'h06
`define REG_IDX_RSV3 6'h12
`define REG_IDX_RSV4 6'h13

// status register fields
`define ST_COMPLETE_BIT 7
`define ST_ACC_ERR_BIT 5
`define ST_PROT_VIOL_BIT 4
`define ST_VERIFY_ERR_BIT 1
`define ST_VERIFY_UNC_BIT 0

// protection register fields
`define PROT_EN_BIT 2
`define PROT_SIZE_LSB 0

// interrupt status and mask fields
`define IRQ_DONE_BIT 0
`define IRQ_ERR_BIT 1

// reset values
`define CLKDIV_RST 7'h00
`define PROT_RST 3'h0
`define IRQ_MASK_RST 2'h0

// commands and parameter slots
`define CMD_PROGRAM 8'h06
`define CMD_PROGRAM_ONCE 8'h07
`define LAST_PARAM_IDX 3'h5
`define NUM_PARAMS 6
`define ONCE_PHRASES 8

// global address map
`define FLASH_LO 23'h7F_0000
`define FLASH_HI 23'h7F_FFFF
`define PROT_LOW_BASE 23'h7F_8000
`define PROT_LOW_UNIT 23'h00_0400
`define PROT_LOAD_ADDR 23'h7F_FF0C

// timing counts
`define PROG_TICKS 8'h10
`define LOAD_CYCLES 2'h3

`endif

/* File: design/flash_seq_pkg.sv */
// types shared by the flash command sequencer
package flash_seq_pkg;

  // sequencer states
  typedef enum logic [2:0] {
    S_LOAD,
    S_IDLE,
    S_CHECK,
    S_PROG,
    S_WAIT,
    S_VERIFY
  } seq_state_t;

endpackage : flash_seq_pkg

/* File: design/once_field_mem.sv */
// program-once reserved field: phrases with registered read data
`timescale 1ns/10ps
module once_field_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 64,
  parameter int AW = 3
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // write port
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  // read port
  input wire logic [AW-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [DEPTH-1:0] written_q;

  // storage has no reset, only the written marks and the read data register do
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  // a phrase never written reads erased, all ones
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      written_q <= '0;
    end else if (wr_en_in) begin
      written_q[wr_addr_in] <= 1'b1;
    end
  end

  // registered read data
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_data_out <= '1;
    end else if (written_q[rd_addr_in]) begin
      rd_data_out <= mem_q[rd_addr_in];
    end else begin
      rd_data_out <= '1;
    end
  end

endmodule : once_field_mem

/* File: design/flash_program_once_sequencer.sv */
// flash command sequencer: program and program-once with error checks
//
// Overview of operation
// R1: program launch with parameter index not 101 sets access error
// R2: command not allowed in current chip mode sets access error
// R3: target global address outside the array sets access error
// R4: target address with low three bits nonzero sets access error
// R5: program target inside protected range sets protection violation
// R6: any verify mismatch sets the verify error bit
// R7: an uncorrectable verify mismatch sets the uncorrectable bit
// R8: program-once writes only the eight reserved 64-bit phrases
// R9: software loads code 07, phrase index, then four data words
// R10: check phrase erased, then program, then verify by read back
// R11: launch by clearing complete flag; flag clear until operation ends
// R12: a second program-once of the same phrase is refused
// R13: block 0 reads are invalid while program-once runs
// R14: lower protection size selects 1, 2, 4 or 8 Kbytes at 7F8000
// R15: protection settings load from 7FFF0C at reset, then writable
// R16: two factory reserved registers read zero and ignore writes
// R17: program timebase is the clock divided by the divider register value plus one
// R18: a flagged launch starts nothing and completes at once
`timescale 1ns/10ps
`include "flash_seq_cfg.svh"
module flash_program_once_sequencer #(
  parameter int DIV_W = 7,
  parameter int TICK_W = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // avalon-mm slave
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // interrupt
  output logic irq_out,
  // chip operating mode pins
  input wire logic [1:0] chip_mode_in,
  // main array port
  input wire logic [63:0] arr_rdback_in,
  output logic arr_wr_out,
  output logic [22:0] arr_addr_out,
  output logic [63:0] arr_data_out,
  // block 0 read data invalid
  output logic block0_invalid_out
);

  flash_seq_pkg::seq_state_t state_q;
  logic [1:0] mode_meta_q;
  logic [1:0] mode_sync_q;
  logic [DIV_W-1:0] flash_clock_divider_q;
  logic [DIV_W-1:0] div_cnt_q;
  logic flash_timebase_clock_q;
  logic [TICK_W-1:0] tick_cnt_q;
  logic [1:0] load_cnt_q;
  logic command_complete_flag_q;
  logic access_error_flag_q;
  logic protection_violation_flag_q;
  logic verify_error_flag_q;
  logic verify_uncorrectable_flag_q;
  logic [2:0] command_param_index_q;
  logic [15:0] command_param_word_q [`NUM_PARAMS];
  logic [1:0] protect_low_size_q;
  logic protect_low_en_q;
  logic once_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic done_pulse_q;
  logic err_pulse_q;
  logic [31:0] rdata_d;
  // reset protection word, split into its fields below
  localparam logic [2:0] PROT_RESET = `PROT_RST;

  // bus request decode
  logic req;
  logic bus_wr;
  logic bus_rd;
  logic [5:0] reg_idx;
  assign req = avs_read_in | avs_write_in;
  assign bus_wr = avs_write_in & ~avs_waitrequest_out & avs_byteenable_in[0];
  assign bus_rd = avs_read_in & ~avs_waitrequest_out;
  assign reg_idx = avs_address_in[7:2];

  // command fields from the parameter slots
  logic [7:0] cmd_code;
  logic [22:0] gaddr;
  logic [63:0] phrase_data;
  logic [2:0] once_idx;
  assign cmd_code = command_param_word_q[0][15:8];
  assign gaddr = {command_param_word_q[0][6:0], command_param_word_q[1]};
  assign phrase_data = {command_param_word_q[2], command_param_word_q[3],
                        command_param_word_q[4], command_param_word_q[5]};
  assign once_idx = command_param_word_q[1][2:0];

  // launch and its checks
  logic launch;
  logic is_prog;
  logic is_once;
  logic mode_ok;
  logic addr_bad;
  logic misaligned;
  logic once_idx_bad;
  logic [22:0] prot_end;
  logic in_prot;
  logic acc_err_c;
  logic pviol_c;
  assign launch = bus_wr && reg_idx == `REG_IDX_STATUS
    && avs_writedata_in[`ST_COMPLETE_BIT] && command_complete_flag_q
    && state_q == flash_seq_pkg::S_IDLE;
  assign is_prog = cmd_code == `CMD_PROGRAM;
  assign is_once = cmd_code == `CMD_PROGRAM_ONCE;
  // program-once locked out in special modes, unknown codes never run
  assign mode_ok = is_prog | (is_once & ~mode_sync_q[1]); // R2
  assign addr_bad = gaddr < `FLASH_LO || gaddr > `FLASH_HI; // R3
  assign misaligned = gaddr[2:0] != 3'h0; // R4
  assign once_idx_bad = command_param_word_q[1] >= 16'(`ONCE_PHRASES); // R8
  assign prot_end = `PROT_LOW_BASE
    + (`PROT_LOW_UNIT << protect_low_size_q); // R14
  assign in_prot = protect_low_en_q && gaddr >= `PROT_LOW_BASE
    && gaddr < prot_end; // R14
  assign acc_err_c = command_param_index_q != `LAST_PARAM_IDX // R1
    || !mode_ok // R2
    || (is_prog && (addr_bad || misaligned)) // R3 R4
    || (is_once && once_idx_bad); // R8
  assign pviol_c = is_prog && !addr_bad && in_prot; // R5

  // reserved field memory and the selected read back
  logic [63:0] once_rd;
  logic once_we;
  logic [63:0] rdback;
  logic [63:0] diff;
  logic erased;
  assign once_we = state_q == flash_seq_pkg::S_PROG && once_q; // R8
  assign rdback = once_q ? once_rd : arr_rdback_in;
  assign diff = rdback ^ phrase_data;
  assign erased = &once_rd;

  once_field_mem #(
    .DEPTH(`ONCE_PHRASES),
    .WIDTH(64),
    .AW(3)
  ) u_once_mem (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .wr_en_in(once_we),
    .wr_addr_in(once_idx),
    .wr_data_in(phrase_data),
    .rd_addr_in(once_idx),
    .rd_data_out(once_rd)
  );

  // mode pins pass two flops before use
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_meta_q <= 2'h0;
      mode_sync_q <= 2'h0;
    end else begin
      mode_meta_q <= chip_mode_in;
      mode_sync_q <= mode_meta_q;
    end
  end

  // timebase divider, one enable pulse per divider period
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div_cnt_q <= '0;
      flash_timebase_clock_q <= 1'b0;
    end else if (div_cnt_q >= flash_clock_divider_q) begin
      div_cnt_q <= '0;
      flash_timebase_clock_q <= 1'b1; // R17
    end else begin
      div_cnt_q <= div_cnt_q + 1'b1;
      flash_timebase_clock_q <= 1'b0;
    end
  end

  // divider register, only changed while idle
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flash_clock_divider_q <= DIV_W'(`CLKDIV_RST);
    end else if (bus_wr && reg_idx == `REG_IDX_CLKDIV
                 && state_q == flash_seq_pkg::S_IDLE) begin
      flash_clock_divider_q <= avs_writedata_in[DIV_W-1:0]; // R17
    end
  end

  // parameter index and slots; locked while a command runs
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      command_param_index_q <= 3'h0;
      for (int i = 0; i < `NUM_PARAMS; i++) begin
        command_param_word_q[i] <= 16'h0000;
      end
    end else if (bus_wr && command_complete_flag_q) begin
      if (reg_idx == `REG_IDX_PINDEX) begin
        command_param_index_q <= avs_writedata_in[2:0];
      end else if (reg_idx == `REG_IDX_PWORD
                   && command_param_index_q <= `LAST_PARAM_IDX) begin
        command_param_word_q[command_param_index_q] <=
          avs_writedata_in[15:0]; // R9
      end
    end
  end

  // protection: loaded from the array at start-up, then writable
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      protect_low_size_q <= PROT_RESET[`PROT_SIZE_LSB +: 2];
      protect_low_en_q <= PROT_RESET[`PROT_EN_BIT];
    end else if (state_q == flash_seq_pkg::S_LOAD
                 && load_cnt_q == `LOAD_CYCLES) begin
      protect_low_size_q <= arr_rdback_in[`PROT_SIZE_LSB +: 2]; // R15
      protect_low_en_q <= arr_rdback_in[`PROT_EN_BIT]; // R15
    end else if (bus_wr && reg_idx == `REG_IDX_PROT
                 && state_q == flash_seq_pkg::S_IDLE) begin
      protect_low_size_q <= avs_writedata_in[`PROT_SIZE_LSB +: 2]; // R15
      protect_low_en_q <= avs_writedata_in[`PROT_EN_BIT];
    end
  end

  // sequencer: load, check, program, wait, verify
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= flash_seq_pkg::S_LOAD;
      load_cnt_q <= 2'h0;
      tick_cnt_q <= '0;
      once_q <= 1'b0;
      command_complete_flag_q <= 1'b0;
      arr_wr_out <= 1'b0;
      arr_addr_out <= `PROT_LOAD_ADDR;
      arr_data_out <= 64'h0;
      done_pulse_q <= 1'b0;
      err_pulse_q <= 1'b0;
    end else begin
      arr_wr_out <= 1'b0;
      done_pulse_q <= 1'b0;
      err_pulse_q <= 1'b0;
      case (state_q)
        flash_seq_pkg::S_LOAD: begin
          // array address held at the protection word while it settles
          load_cnt_q <= load_cnt_q + 1'b1;
          if (load_cnt_q == `LOAD_CYCLES) begin
            command_complete_flag_q <= 1'b1;
            state_q <= flash_seq_pkg::S_IDLE;
          end
        end
        flash_seq_pkg::S_IDLE: begin
          if (launch) begin
            once_q <= is_once;
            arr_addr_out <= gaddr;
            arr_data_out <= phrase_data;
            if (acc_err_c || pviol_c) begin
              err_pulse_q <= 1'b1; // R18
              done_pulse_q <= 1'b1; // R18
            end else begin
              command_complete_flag_q <= 1'b0; // R11
              state_q <= is_once ? flash_seq_pkg::S_CHECK
                                 : flash_seq_pkg::S_PROG;
            end
          end
        end
        flash_seq_pkg::S_CHECK: begin
          // registered read of the phrase is ready one cycle on
          if (!erased) begin
            err_pulse_q <= 1'b1; // R12
            done_pulse_q <= 1'b1;
            command_complete_flag_q <= 1'b1; // R12
            state_q <= flash_seq_pkg::S_IDLE;
          end else begin
            state_q <= flash_seq_pkg::S_PROG; // R10
          end
        end
        flash_seq_pkg::S_PROG: begin
          arr_wr_out <= ~once_q;
          tick_cnt_q <= '0;
          state_q <= flash_seq_pkg::S_WAIT; // R10
        end
        flash_seq_pkg::S_WAIT: begin
          if (flash_timebase_clock_q) begin
            tick_cnt_q <= tick_cnt_q + 1'b1; // R17
            if (tick_cnt_q == `PROG_TICKS - 8'h01) begin
              state_q <= flash_seq_pkg::S_VERIFY;
            end
          end
        end
        flash_seq_pkg::S_VERIFY: begin
          err_pulse_q <= diff != 64'h0;
          done_pulse_q <= 1'b1;
          command_complete_flag_q <= 1'b1; // R11
          state_q <= flash_seq_pkg::S_IDLE;
        end
        default: begin
          state_q <= flash_seq_pkg::S_IDLE;
        end
      endcase
    end
  end

  // error flags: cleared by writing one, a new set wins
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      access_error_flag_q <= 1'b0;
      protection_violation_flag_q <= 1'b0;
    end else begin
      if (bus_wr && reg_idx == `REG_IDX_STATUS) begin
        if (avs_writedata_in[`ST_ACC_ERR_BIT]) begin
          access_error_flag_q <= 1'b0;
        end
        if (avs_writedata_in[`ST_PROT_VIOL_BIT]) begin
          protection_violation_flag_q <= 1'b0;
        end
      end
      if (launch && acc_err_c) begin
        access_error_flag_q <= 1'b1; // R1 R2 R3 R4
      end
      if (launch && pviol_c) begin
        protection_violation_flag_q <= 1'b1; // R5
      end
      if (state_q == flash_seq_pkg::S_CHECK && !erased) begin
        access_error_flag_q <= 1'b1; // R12
      end
    end
  end

  // verify results, cleared by each new accepted launch
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      verify_error_flag_q <= 1'b0;
      verify_uncorrectable_flag_q <= 1'b0;
    end else if (state_q == flash_seq_pkg::S_VERIFY) begin
      verify_error_flag_q <= diff != 64'h0; // R6
      // one flipped bit is correctable, more is not
      verify_uncorrectable_flag_q <= $countones(diff) > 1; // R7
    end else if (launch && !acc_err_c && !pviol_c) begin
      verify_error_flag_q <= 1'b0;
      verify_uncorrectable_flag_q <= 1'b0;
    end
  end

  // block 0 read data flagged invalid during program-once
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      block0_invalid_out <= 1'b0;
    end else begin
      block0_invalid_out <= once_q && (state_q == flash_seq_pkg::S_CHECK
        || state_q == flash_seq_pkg::S_PROG
        || state_q == flash_seq_pkg::S_WAIT); // R13
    end
  end

  // interrupt status: sticky, cleared by reading, set wins
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_stat_q <= 2'h0;
      irq_mask_q <= `IRQ_MASK_RST;
      irq_out <= 1'b0;
    end else begin
      if (bus_rd && reg_idx == `REG_IDX_IRQ_STAT) begin
        irq_stat_q <= 2'h0;
      end
      if (bus_wr && reg_idx == `REG_IDX_IRQ_MASK) begin
        irq_mask_q <= avs_writedata_in[1:0];
      end
      if (done_pulse_q) begin
        irq_stat_q[`IRQ_DONE_BIT] <= 1'b1;
      end
      if (err_pulse_q) begin
        irq_stat_q[`IRQ_ERR_BIT] <= 1'b1;
      end
      irq_out <= |(irq_stat_q & irq_mask_q);
    end
  end

  // read mux; unmapped and reserved words read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_idx == `REG_IDX_CLKDIV) begin
      rdata_d[DIV_W-1:0] = flash_clock_divider_q;
    end else if (reg_idx == `REG_IDX_STATUS) begin
      rdata_d[`ST_COMPLETE_BIT] = command_complete_flag_q;
      rdata_d[`ST_ACC_ERR_BIT] = access_error_flag_q;
      rdata_d[`ST_PROT_VIOL_BIT] = protection_violation_flag_q;
      rdata_d[`ST_VERIFY_ERR_BIT] = verify_error_flag_q;
      rdata_d[`ST_VERIFY_UNC_BIT] = verify_uncorrectable_flag_q;
    end else if (reg_idx == `REG_IDX_PINDEX) begin
      rdata_d[2:0] = command_param_index_q;
    end else if (reg_idx == `REG_IDX_PWORD) begin
      if (command_param_index_q <= `LAST_PARAM_IDX) begin
        rdata_d[15:0] = command_param_word_q[command_param_index_q];
      end
    end else if (reg_idx == `REG_IDX_PROT) begin
      rdata_d[`PROT_SIZE_LSB +: 2] = protect_low_size_q;
      rdata_d[`PROT_EN_BIT] = protect_low_en_q;
    end else if (reg_idx == `REG_IDX_IRQ_STAT) begin
      rdata_d[1:0] = irq_stat_q;
    end else if (reg_idx == `REG_IDX_IRQ_MASK) begin
      rdata_d[1:0] = irq_mask_q;
    end else if (reg_idx == `REG_IDX_RSV3 || reg_idx == `REG_IDX_RSV4) begin
      rdata_d = 32'h0000_0000; // R16
    end
  end

  // bus handshake: one wait cycle, answer on the second edge
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      avs_waitrequest_out <= ~(req & avs_waitrequest_out);
      if (req && avs_waitrequest_out) begin
        avs_readdata_out <= rdata_d;
      end
    end
  end

endmodule : flash_program_once_sequencer

/* File: tb/flash_program_once_sequencer_chk.sv */
// port assertions of the flash command sequencer
`timescale 1ns/10ps
`include "flash_seq_cfg.svh"
module flash_seq_chk (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // register bus
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  // array port and status pins
  input wire logic arr_wr_out,
  input wire logic [22:0] arr_addr_out,
  input wire logic block0_invalid_out,
  input wire logic irq_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  // any request on the bus
  logic req;
  assign req = avs_read_in || avs_write_in;
  // bus handshake
  property p_wait_idle;
    !req |-> avs_waitrequest_out;
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("waitrequest low without request");
  property p_wait_answer;
    $rose(req) |-> avs_waitrequest_out ##1 !avs_waitrequest_out;
  endproperty
  a_wait_answer: assert property (p_wait_answer)
    else $error("answer not one cycle after request");
  property p_wait_one;
    !avs_waitrequest_out |=> avs_waitrequest_out;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest low for more than one cycle");
  // read data must not drift between accesses
  property p_rdata_hold;
    !req |=> $stable(avs_readdata_out);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without request");
  // array programming pulses
  property p_wr_space;
    arr_wr_out |=> !arr_wr_out [*8];
  endproperty
  a_wr_space: assert property (p_wr_space)
    else $error("program pulses too close");
  property p_aligned;
    arr_wr_out |-> arr_addr_out[2:0] == 3'h0;
  endproperty
  a_aligned: assert property (p_aligned)
    else $error("program at unaligned address");
  property p_in_array;
    arr_wr_out && !block0_invalid_out |-> arr_addr_out >= `FLASH_LO;
  endproperty
  a_in_array: assert property (p_in_array)
    else $error("program outside the array");
  // block 0 stays hidden through the program wait; a refused
  // second attempt hides it for its one check cycle only
  property p_once_hide;
    $rose(block0_invalid_out) ##1 block0_invalid_out
      |=> block0_invalid_out [*8];
  endproperty
  a_once_hide: assert property (p_once_hide)
    else $error("block 0 shown during program-once");
  c_once: cover property ($rose(block0_invalid_out) ##1 block0_invalid_out);
  c_prog: cover property (arr_wr_out && !block0_invalid_out);
  c_irq: cover property ($rose(irq_out));
endmodule : flash_seq_chk

bind flash_program_once_sequencer flash_seq_chk i_flash_seq_chk (
  .clk_in(clk_in),
  .resetn_in(resetn_in),
  .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out),
  .arr_wr_out(arr_wr_out),
  .arr_addr_out(arr_addr_out),
  .block0_invalid_out(block0_invalid_out),
  .irq_out(irq_out)
);

/* File: tb/flash_program_once_sequencer_test.sv */
// self-checking bench of the flash command sequencer
`timescale 1ns/10ps
`include "flash_seq_cfg.svh"
module flash_program_once_sequencer_test;
  localparam logic [5:0] DIV = `REG_IDX_CLKDIV;
  localparam logic [5:0] ST = `REG_IDX_STATUS;
  localparam logic [5:0] PIX = `REG_IDX_PINDEX;
  localparam logic [5:0] PW = `REG_IDX_PWORD;
  localparam logic [5:0] PROT = `REG_IDX_PROT;
  localparam logic [5:0] IST = `REG_IDX_IRQ_STAT;
  localparam logic [5:0] IMK = `REG_IDX_IRQ_MASK;
  // prot, mode, last index, status, slot 0, slot 1
  localparam logic [63:0] TBL [10] = '{
    64'h5040_A000_067F_0000, 64'h5050_A000_097F_0000,
    64'h5050_A000_067E_FFF8, 64'h5050_A000_067F_0004,
    64'h5050_9000_067F_87F8, 64'h7050_9000_067F_9FF8,
    64'h4050_8000_067F_8400, 64'h5050_8000_067F_8800,
    64'h5050_A000_0700_0008, 64'h5250_A000_0700_0001};
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] avs_address_in = 8'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0] avs_byteenable_in = 4'hF;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic irq_out;
  logic [1:0] chip_mode_in = 2'h0;
  logic [63:0] arr_rdback_in;
  logic arr_wr_out;
  logic [22:0] arr_addr_out;
  logic [63:0] arr_data_out;
  logic block0_invalid_out;
  logic [63:0] mem [logic [22:0]];
  logic [63:0] flip = 64'h0;
  logic inv_seen = 1'b0;
  logic [31:0] q;
  int cyc = 0;
  int wcnt = 0;
  int t0 = 0;
  int np = 0;
  int errors = 0;
  int comparisons = 0;

  flash_program_once_sequencer i_flash_program_once_sequencer (
    .clk_in(clk_in), .resetn_in(resetn_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out),
    .chip_mode_in(chip_mode_in), .arr_rdback_in(arr_rdback_in),
    .arr_wr_out(arr_wr_out), .arr_addr_out(arr_addr_out),
    .arr_data_out(arr_data_out), .block0_invalid_out(block0_invalid_out));

  initial begin
    forever #2.5 clk_in = ~clk_in;
  end
  // array read back is combinational; flip injects verify faults
  always @(arr_addr_out or flip or wcnt) begin
    if (arr_addr_out == `PROT_LOAD_ADDR) arr_rdback_in = 64'h5;
    else if (mem.exists(arr_addr_out))
      arr_rdback_in = mem[arr_addr_out] ^ flip;
    else arr_rdback_in = ~flip; // erased reads all ones
  end
  // array writes and hidden-block watch
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (block0_invalid_out === 1'b1) inv_seen <= 1'b1;
    if (arr_wr_out === 1'b1) begin
      mem[arr_addr_out] = arr_data_out;
      wcnt <= wcnt + 1;
    end
  end

  task automatic check(input string n, input logic [63:0] s,
    input logic [63:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : check
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a,
    input logic [31:0] d);
    @(posedge clk_in);
    avs_address_in <= {a, 2'b00};
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= ~w;
    // only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask : bus
  task automatic rc(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), 64'(q), 64'(e));
  endtask : rc
  // load the six slots, set the final index, launch
  task automatic launch(input logic [15:0] s0, input logic [15:0] s1,
    input logic [63:0] d, input logic [2:0] last);
    logic [15:0] s [6];
    s = '{s0, s1, d[63:48], d[47:32], d[31:16], d[15:0]};
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, PIX, 32'(i));
      bus(1'b1, PW, {16'h0, s[i]});
    end
    bus(1'b1, PIX, {29'h0, last});
    bus(1'b1, ST, 32'h80);
    t0 = cyc;
  endtask : launch
  // poll status until complete, bounded
  task automatic wait_done;
    np = 0;
    do begin
      bus(1'b0, ST, 32'h0);
      np++;
    end while (q[7] !== 1'b1 && np < 200);
    if (q[7] !== 1'b1) errors++;
  endtask : wait_done
  task automatic conclude;
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  // watchdog well beyond the expected run
  initial begin
    repeat (40000) @(posedge clk_in);
    errors++;
    conclude;
  end

  initial begin
    logic [63:0] e;
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b1;
    wait_done;
    check("load status", 64'(q), 64'h80);
    rc(PROT, 32'h5);
    rc(DIV, 32'h0);
    rc(IMK, 32'h0);
    bus(1'b1, 6'h12, 32'hFF);
    bus(1'b1, 6'h13, 32'hFF);
    rc(6'h12, 32'h0);
    rc(6'h13, 32'h0);
    rc(6'h20, 32'h0);
    avs_byteenable_in <= 4'h0;
    bus(1'b1, DIV, 32'h3);
    avs_byteenable_in <= 4'hF;
    rc(DIV, 32'h0);
    // timebase follows the divider
    bus(1'b1, DIV, 32'h3);
    launch(16'h067F, 16'h0008, 64'h0123_4567_89AB_CDEF, 3'h5);
    wait_done;
    check("slow time", 64'(cyc - t0 > 63), 64'h1);
    check("slow status", 64'(q), 64'h80);
    check("array", mem[23'h7F_0008], 64'h0123_4567_89AB_CDEF);
    bus(1'b1, DIV, 32'h0);
    launch(16'h067F, 16'h0010, 64'h0F0F_0F0F_0F0F_0F0F, 3'h5);
    wait_done;
    check("fast time", 64'(cyc - t0 < 48), 64'h1);
    // launch checks; rejected ones never drop complete
    for (int i = 0; i < 10; i++) begin
      e = TBL[i];
      bus(1'b1, PROT, {28'h0, e[63:60]});
      chip_mode_in <= e[57:56];
      repeat (3) @(posedge clk_in);
      launch(e[31:16], e[15:0], 64'h0, e[54:52]);
      wait_done;
      check("table status", 64'(q), 64'(e[47:40]));
      check("table polls", 64'(np == 1), 64'(e[47:40] != 8'h80));
      bus(1'b1, ST, 32'h30);
    end
    chip_mode_in <= 2'h0;
    bus(1'b1, PROT, 32'h5);
    check("hidden before", 64'(inv_seen), 64'h0);
    // program-once, then a refused second attempt
    launch(16'h0700, 16'h0002, 64'hA5A5_5A5A_1234_8765, 3'h5);
    wait_done;
    check("once status", 64'(q), 64'h80);
    check("hidden during", 64'(inv_seen), 64'h1);
    launch(16'h0700, 16'h0002, 64'h0, 3'h5);
    wait_done;
    check("second once", 64'(q), 64'hA0);
    // refused at the check step, so the first poll already sees complete
    check("second polls", 64'(np), 64'h1);
    bus(1'b1, ST, 32'h30);
    // verify faults: one bit, then two bits
    flip <= 64'h1;
    launch(16'h067F, 16'h0018, 64'h1111, 3'h5);
    wait_done;
    check("verify one", 64'(q), 64'h82);
    flip <= 64'h3;
    launch(16'h067F, 16'h0020, 64'h2222, 3'h5);
    wait_done;
    check("verify two", 64'(q), 64'h83);
    flip <= 64'h0;
    // interrupt masked, unmasked, cleared by read
    bus(1'b0, IST, 32'h0);
    launch(16'h067F, 16'h0004, 64'h0, 3'h5);
    wait_done;
    check("irq masked", 64'(irq_out), 64'h0);
    bus(1'b1, IMK, 32'h2);
    repeat (2) @(posedge clk_in);
    check("irq raised", 64'(irq_out), 64'h1);
    rc(IST, 32'h3);
    repeat (3) @(posedge clk_in);
    check("irq cleared", 64'(irq_out), 64'h0);
    conclude;
  end
endmodule : flash_program_once_sequencer_test
